// >>> shared/ldmf_defs.svh
// Constants for the LCD display mode and fetch register bank
// Function
// R01 - Depth codes 2..5 give 4/8/15/16 bpp
// R02 - 15/16 bpp bypass the lookup table
// R03 - Dither off: no dithering at 15/16 bpp
// R04 - Dither on: passive 15/16 bpp dithered
// R05 - Dither bit ignored at 4/8 bpp
// R06 - Buffer-off bit 1 disables dual buffer
// R07 - Single panel forces dual buffer off
// R08 - Start address is 20-bit word address
// R09 - Next line start adds 11-bit offset
// R10 - Larger offset shows window into image
// R11 - Pan value shifts image left pixels
// R12 - Pan bits used depend on depth
// R13 - Software combines pan with start address
// R14 - Software disables dual buffer before blanking
// R15 - Software avoids reserved depth codes
`ifndef LDMF_DEFS_SVH
`define LDMF_DEFS_SVH

// ----------------------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------------------
`define LDMF_IDX_MODE 8'h40
`define LDMF_IDX_MISC 8'h41
`define LDMF_IDX_SA_LO 8'h42
`define LDMF_IDX_SA_MID 8'h43
`define LDMF_IDX_SA_HI 8'h44
`define LDMF_IDX_LO_LO 8'h46
`define LDMF_IDX_LO_HI 8'h47
`define LDMF_IDX_PAN 8'h48
`define LDMF_IDX_FIFO_HI 8'h4A
`define LDMF_IDX_PANEL 8'h4C
`define LDMF_IDX_STATUS 8'h4D
`define LDMF_IDX_LADDR 8'h4E

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define LDMF_MISC_DUAL_OFF 0
`define LDMF_MISC_DITHER_OFF 1
`define LDMF_PANEL_DUAL 0
`define LDMF_PANEL_PASSIVE 1

// ----------------------------------------------------------------------------
// Depth codes, reset values, bus codes
// ----------------------------------------------------------------------------
`define LDMF_BPP_4 3'h2
`define LDMF_BPP_8 3'h3
`define LDMF_BPP_15 3'h4
`define LDMF_BPP_16 3'h5
`define LDMF_RST_BYTE 8'h00
`define LDMF_RST_ADDR 20'h0_0000
`define LDMF_HTRANS_NONSEQ 2'h2
`define LDMF_HRESP_OKAY 1'b0
`define LDMF_HIGH_ZERO 22'h00_0000

`endif

// >>> shared/ldmf_pkg.sv
// Types shared by the LCD display mode and fetch register bank
package ldmf_pkg;

  // Software configuration as held in the registers
  typedef struct packed {
    logic [2:0] bpp;
    logic dither_off;
    logic dual_buf_off;
    logic [19:0] start_addr;
    logic [10:0] line_offset;
    logic [1:0] pan;
    logic [5:0] fifo_high;
    logic dual_panel;
    logic passive_panel;
  } ldmf_cfg_t;

  // Decoded pixel path mode
  typedef struct packed {
    logic depth_valid;
    logic lut_bypass;
    logic dither_en;
    logic dual_buf_en;
    logic [1:0] pan_shift;
  } ldmf_mode_t;

endpackage

// >>> rtl/ldmf_pixel_mode.sv
// Decode of the configuration into the pixel path mode
`timescale 1ns/1ps
`default_nettype none
`include "ldmf_defs.svh"

module ldmf_pixel_mode (
  input wire ldmf_pkg::ldmf_cfg_t i_cfg, // Current configuration
  output var ldmf_pkg::ldmf_mode_t o_mode // Decoded mode, combinational
);

  // ----------------------------------------------------------------------------
  // Depth classification
  // ----------------------------------------------------------------------------
  wire logic is_4 = (i_cfg.bpp == `LDMF_BPP_4); // R01
  wire logic is_8 = (i_cfg.bpp == `LDMF_BPP_8); // R01
  wire logic is_hi = (i_cfg.bpp == `LDMF_BPP_15) | (i_cfg.bpp == `LDMF_BPP_16); // R01

  // Reserved codes give no image: no bypass, no dither, no pan; dual buffer still follows its bits
  assign o_mode.depth_valid = is_4 | is_8 | is_hi; // R01
  // Direct colour skips the lookup table
  assign o_mode.lut_bypass = is_hi; // R02
  // Only passive panels at 15/16 bpp dither; 4/8 bpp never do
  assign o_mode.dither_en = is_hi & i_cfg.passive_panel & ~i_cfg.dither_off; // R03 R04 R05
  // Single panel keeps the buffer off whatever software wrote
  assign o_mode.dual_buf_en = i_cfg.dual_panel & ~i_cfg.dual_buf_off; // R06 R07
  // Pan width shrinks as pixels grow; 15/16 bpp cannot pan
  assign o_mode.pan_shift = is_4 ? i_cfg.pan : (is_8 ? {1'b0, i_cfg.pan[0]} : 2'h0); // R11 R12

endmodule // ldmf_pixel_mode
`default_nettype wire

// >>> rtl/ldmf_line_addr.sv
// Line start word address generator for the display fetch
`timescale 1ns/1ps
`default_nettype none
`include "ldmf_defs.svh"

module ldmf_line_addr (
  input wire logic i_clk, // System clock
  input wire logic i_rst, // Synchronous reset, active high
  input wire logic i_frame_start, // Pulse: first line of a frame
  input wire logic i_line_start, // Pulse: advance to next line
  input wire logic [19:0] i_start_addr, // Word address of first word
  input wire logic [10:0] i_line_offset, // Words from line to line
  output logic [19:0] o_line_addr // Start word of current line
);

  // ----------------------------------------------------------------------------
  // Address arithmetic
  // ----------------------------------------------------------------------------
  // Wraps at 20 bits; an offset wider than the panel line just skips words
  wire logic [20:0] sum = {1'b0, o_line_addr} + {10'h000, i_line_offset}; // R09 R10
  wire logic [19:0] next_line_addr = i_frame_start ? i_start_addr : (i_line_start ? sum[19:0] : o_line_addr);

  // Frame start wins over a line step in the same cycle
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_line_addr <= `LDMF_RST_ADDR;
    end else begin
      o_line_addr <= next_line_addr; // R08 R09
    end
  end

  // ----------------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------------
  a_frame_load: assert property (@(posedge i_clk) disable iff (i_rst) // R08
    i_frame_start |=> o_line_addr == $past(i_start_addr))
    else $error("line address not loaded from start address");

  a_line_step: assert property (@(posedge i_clk) disable iff (i_rst) // R09
    (i_line_start && !i_frame_start) |=> o_line_addr == 20'($past(o_line_addr) + $past(i_line_offset)))
    else $error("line address did not advance by offset");

  a_line_hold: assert property (@(posedge i_clk) disable iff (i_rst) // R09
    (!i_line_start && !i_frame_start) |=> $stable(o_line_addr))
    else $error("line address moved without a line event");

endmodule // ldmf_line_addr
`default_nettype wire

// >>> rtl/ldmf_regs.sv
// AHB-Lite register bank for the LCD display mode and fetch settings
`timescale 1ns/1ps
`default_nettype none
`include "ldmf_defs.svh"

module ldmf_regs (
  input wire logic i_clk, // System clock, 100 MHz
  input wire logic i_rst, // Synchronous reset, active high
  input wire logic i_hsel, // AHB slave select
  input wire logic [31:0] i_haddr, // AHB byte address
  input wire logic [1:0] i_htrans, // AHB transfer type
  input wire logic i_hwrite, // AHB write when high
  input wire logic [2:0] i_hsize, // AHB size, word only
  input wire logic [31:0] i_hwdata, // AHB write data
  input wire logic i_hready, // AHB bus ready
  output logic o_hreadyout, // Always ready, no wait states
  output logic o_hresp, // Always OKAY
  output logic [31:0] o_hrdata, // Registered read data
  input wire logic i_frame_start, // Pulse: frame begins
  input wire logic i_line_start, // Pulse: next display line
  output logic [19:0] o_line_addr, // Start word of current line
  output var ldmf_pkg::ldmf_mode_t o_mode, // Registered pixel mode
  output var ldmf_pkg::ldmf_cfg_t o_cfg // Register contents
);

  // ----------------------------------------------------------------------------
  // Address phase
  // ----------------------------------------------------------------------------
  // Only NONSEQ and SEQ carry a transfer; hsize is not checked, word access only
  wire logic addr_take = i_hsel & i_hready & i_htrans[1];
  wire logic [7:0] addr_idx = i_haddr[9:2];
  wire logic addr_in_map = (i_haddr[31:10] == `LDMF_HIGH_ZERO);
  wire logic wr_take = addr_take & i_hwrite & addr_in_map;
  wire logic rd_take = addr_take & ~i_hwrite;
  wire logic size_unused = ^i_hsize;

  logic wr_pend;
  logic [7:0] wr_idx;

  // Write is committed in the data phase, when hwdata stands
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      wr_pend <= 1'b0;
      wr_idx <= `LDMF_RST_BYTE;
    end else begin
      wr_pend <= wr_take;
      wr_idx <= addr_idx;
    end
  end

  // ----------------------------------------------------------------------------
  // Write strobes
  // ----------------------------------------------------------------------------
  wire logic wr_mode = wr_pend & (wr_idx == `LDMF_IDX_MODE);
  wire logic wr_misc = wr_pend & (wr_idx == `LDMF_IDX_MISC);
  wire logic wr_sa_lo = wr_pend & (wr_idx == `LDMF_IDX_SA_LO);
  wire logic wr_sa_mid = wr_pend & (wr_idx == `LDMF_IDX_SA_MID);
  wire logic wr_sa_hi = wr_pend & (wr_idx == `LDMF_IDX_SA_HI);
  wire logic wr_lo_lo = wr_pend & (wr_idx == `LDMF_IDX_LO_LO);
  wire logic wr_lo_hi = wr_pend & (wr_idx == `LDMF_IDX_LO_HI);
  wire logic wr_pan = wr_pend & (wr_idx == `LDMF_IDX_PAN);
  wire logic wr_fifo = wr_pend & (wr_idx == `LDMF_IDX_FIFO_HI);
  wire logic wr_panel = wr_pend & (wr_idx == `LDMF_IDX_PANEL);

  // ----------------------------------------------------------------------------
  // Register storage
  // ----------------------------------------------------------------------------
  logic [2:0] bpp;
  logic dither_off;
  logic dual_buf_off;
  logic [7:0] sa_lo;
  logic [7:0] sa_mid;
  logic [3:0] sa_hi;
  logic [7:0] lo_lo;
  logic [2:0] lo_hi;
  logic [1:0] pan;
  logic [5:0] fifo_high;
  logic dual_panel;
  logic passive_panel;

  // Next values; reads use them so a read right after a write sees new data
  wire logic [2:0] next_bpp = wr_mode ? i_hwdata[2:0] : bpp; // R01
  wire logic next_dither_off = wr_misc ? i_hwdata[`LDMF_MISC_DITHER_OFF] : dither_off; // R03 R04
  wire logic next_dual_buf_off = wr_misc ? i_hwdata[`LDMF_MISC_DUAL_OFF] : dual_buf_off; // R06
  wire logic [7:0] next_sa_lo = wr_sa_lo ? i_hwdata[7:0] : sa_lo; // R08
  wire logic [7:0] next_sa_mid = wr_sa_mid ? i_hwdata[7:0] : sa_mid; // R08
  wire logic [3:0] next_sa_hi = wr_sa_hi ? i_hwdata[3:0] : sa_hi; // R08
  wire logic [7:0] next_lo_lo = wr_lo_lo ? i_hwdata[7:0] : lo_lo; // R09
  wire logic [2:0] next_lo_hi = wr_lo_hi ? i_hwdata[2:0] : lo_hi; // R09
  wire logic [1:0] next_pan = wr_pan ? i_hwdata[1:0] : pan; // R11
  wire logic [5:0] next_fifo_high = wr_fifo ? i_hwdata[5:0] : fifo_high;
  wire logic next_dual_panel = wr_panel ? i_hwdata[`LDMF_PANEL_DUAL] : dual_panel;
  wire logic next_passive_panel = wr_panel ? i_hwdata[`LDMF_PANEL_PASSIVE] : passive_panel;

  // Mode and misc settings
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      bpp <= 3'h0;
      dither_off <= 1'b0;
      dual_buf_off <= 1'b0;
      pan <= 2'h0;
      fifo_high <= 6'h00;
      dual_panel <= 1'b0;
      passive_panel <= 1'b0;
    end else begin
      bpp <= next_bpp;
      dither_off <= next_dither_off;
      dual_buf_off <= next_dual_buf_off;
      pan <= next_pan;
      fifo_high <= next_fifo_high;
      dual_panel <= next_dual_panel;
      passive_panel <= next_passive_panel;
    end
  end

  // Address settings; bytes change one at a time, so software should
  // update them between frames to avoid a torn start address
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      sa_lo <= `LDMF_RST_BYTE;
      sa_mid <= `LDMF_RST_BYTE;
      sa_hi <= 4'h0;
      lo_lo <= `LDMF_RST_BYTE;
      lo_hi <= 3'h0;
    end else begin
      sa_lo <= next_sa_lo;
      sa_mid <= next_sa_mid;
      sa_hi <= next_sa_hi;
      lo_lo <= next_lo_lo;
      lo_hi <= next_lo_hi;
    end
  end

  // ----------------------------------------------------------------------------
  // Configuration assembly and mode decode
  // ----------------------------------------------------------------------------
  ldmf_pkg::ldmf_cfg_t cfg;
  ldmf_pkg::ldmf_mode_t mode_now;

  // Three start bytes form one word address of the first displayed word
  assign cfg.bpp = bpp;
  assign cfg.dither_off = dither_off;
  assign cfg.dual_buf_off = dual_buf_off;
  assign cfg.start_addr = {sa_hi, sa_mid, sa_lo}; // R08
  assign cfg.line_offset = {lo_hi, lo_lo}; // R09
  assign cfg.pan = pan;
  assign cfg.fifo_high = fifo_high;
  assign cfg.dual_panel = dual_panel;
  assign cfg.passive_panel = passive_panel;
  assign o_cfg = cfg;

  ldmf_pixel_mode u_pixel_mode (
    .i_cfg(cfg),
    .o_mode(mode_now)
  );

  // Registered so the pixel path sees a clean, glitch-free mode
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_mode <= '0;
    end else begin
      o_mode <= mode_now; // R02 R03 R04 R05 R06 R07 R12
    end
  end

  ldmf_line_addr u_line_addr (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_frame_start(i_frame_start),
    .i_line_start(i_line_start),
    .i_start_addr(cfg.start_addr),
    .i_line_offset(cfg.line_offset),
    .o_line_addr(o_line_addr)
  );

  // ----------------------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------------------
  // Unused bits read as zero; both pan bits read back as stored at every depth
  wire logic [31:0] rd_mode = {29'h0000_0000, next_bpp};
  wire logic [31:0] rd_misc = {30'h0000_0000, next_dither_off, next_dual_buf_off};
  wire logic [31:0] rd_sa_lo = {24'h00_0000, next_sa_lo};
  wire logic [31:0] rd_sa_mid = {24'h00_0000, next_sa_mid};
  wire logic [31:0] rd_sa_hi = {28'h000_0000, next_sa_hi};
  wire logic [31:0] rd_lo_lo = {24'h00_0000, next_lo_lo};
  wire logic [31:0] rd_lo_hi = {29'h0000_0000, next_lo_hi};
  wire logic [31:0] rd_pan = {30'h0000_0000, next_pan};
  wire logic [31:0] rd_fifo = {26'h000_0000, next_fifo_high};
  wire logic [31:0] rd_panel = {30'h0000_0000, next_passive_panel, next_dual_panel};
  wire logic [31:0] rd_status = {26'h000_0000, mode_now.pan_shift, mode_now.dual_buf_en,
                                 mode_now.dither_en, mode_now.lut_bypass, mode_now.depth_valid};
  wire logic [31:0] rd_laddr = {12'h000, o_line_addr};

  // Unmapped addresses read zero and still answer OKAY
  wire logic [31:0] rd_sel =
    (addr_idx == `LDMF_IDX_MODE) ? rd_mode :
    (addr_idx == `LDMF_IDX_MISC) ? rd_misc :
    (addr_idx == `LDMF_IDX_SA_LO) ? rd_sa_lo :
    (addr_idx == `LDMF_IDX_SA_MID) ? rd_sa_mid :
    (addr_idx == `LDMF_IDX_SA_HI) ? rd_sa_hi :
    (addr_idx == `LDMF_IDX_LO_LO) ? rd_lo_lo :
    (addr_idx == `LDMF_IDX_LO_HI) ? rd_lo_hi :
    (addr_idx == `LDMF_IDX_PAN) ? rd_pan :
    (addr_idx == `LDMF_IDX_FIFO_HI) ? rd_fifo :
    (addr_idx == `LDMF_IDX_PANEL) ? rd_panel :
    (addr_idx == `LDMF_IDX_STATUS) ? rd_status :
    (addr_idx == `LDMF_IDX_LADDR) ? rd_laddr : 32'h0000_0000;
  wire logic [31:0] rd_word = addr_in_map ? rd_sel : 32'h0000_0000;

  // Read data is captured at the address phase edge and stands in the data phase
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_hrdata <= 32'h0000_0000;
    end else if (rd_take) begin
      o_hrdata <= rd_word;
    end
  end

  // Zero wait states and no error responses
  assign o_hreadyout = 1'b1 | size_unused;
  assign o_hresp = `LDMF_HRESP_OKAY;

  // ----------------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------------
  a_depth_valid: assert property (@(posedge i_clk) disable iff (i_rst) // R01
    (bpp >= `LDMF_BPP_4 && bpp <= `LDMF_BPP_16) |=> o_mode.depth_valid)
    else $error("valid depth code not flagged valid");

  a_depth_reserved: assert property (@(posedge i_clk) disable iff (i_rst) // R01
    (bpp < `LDMF_BPP_4 || bpp > `LDMF_BPP_16) |=> (!o_mode.depth_valid && o_mode.pan_shift == 2'h0))
    else $error("reserved depth code not flagged");

  a_lut_bypass: assert property (@(posedge i_clk) disable iff (i_rst) // R02
    (bpp == `LDMF_BPP_15 || bpp == `LDMF_BPP_16) |=> o_mode.lut_bypass)
    else $error("direct colour did not bypass lookup");

  a_lut_through: assert property (@(posedge i_clk) disable iff (i_rst) // R02
    (bpp == `LDMF_BPP_4 || bpp == `LDMF_BPP_8) |=> !o_mode.lut_bypass)
    else $error("indexed colour bypassed lookup");

  a_dither_off: assert property (@(posedge i_clk) disable iff (i_rst) // R03
    dither_off |=> !o_mode.dither_en)
    else $error("dithering while disabled");

  a_dither_on: assert property (@(posedge i_clk) disable iff (i_rst) // R04
    (passive_panel && !dither_off && (bpp == `LDMF_BPP_15 || bpp == `LDMF_BPP_16)) |=> o_mode.dither_en)
    else $error("passive direct colour not dithered");

  a_dither_low: assert property (@(posedge i_clk) disable iff (i_rst) // R05
    (bpp == `LDMF_BPP_4 || bpp == `LDMF_BPP_8) |=> !o_mode.dither_en)
    else $error("dithering at low depth");

  a_dual_buffer: assert property (@(posedge i_clk) disable iff (i_rst) // R06
    dual_panel |=> (o_mode.dual_buf_en == !$past(dual_buf_off)))
    else $error("dual buffer does not follow its bit");

  a_single_panel: assert property (@(posedge i_clk) disable iff (i_rst) // R07
    !dual_panel |=> !o_mode.dual_buf_en)
    else $error("dual buffer on with single panel");

  a_pan_depth: assert property (@(posedge i_clk) disable iff (i_rst) // R12
    (bpp == `LDMF_BPP_8) |=> (o_mode.pan_shift == {1'b0, $past(pan[0])}))
    else $error("8 bpp pan uses wrong bits");

  a_pan_full: assert property (@(posedge i_clk) disable iff (i_rst) // R11
    (bpp == `LDMF_BPP_4) |=> (o_mode.pan_shift == $past(pan)))
    else $error("4 bpp pan not applied");

  a_start_write: assert property (@(posedge i_clk) disable iff (i_rst) // R08
    (wr_take && addr_idx == `LDMF_IDX_SA_LO) ##1 1'b1 |=> (cfg.start_addr[7:0] == $past(i_hwdata[7:0])))
    else $error("start address byte not stored");

  a_start_mid: assert property (@(posedge i_clk) disable iff (i_rst) // R08
    (wr_take && addr_idx == `LDMF_IDX_SA_MID) ##1 1'b1 |=> (cfg.start_addr[15:8] == $past(i_hwdata[7:0])))
    else $error("start address middle byte not stored");

  a_start_high: assert property (@(posedge i_clk) disable iff (i_rst) // R08
    (wr_take && addr_idx == `LDMF_IDX_SA_HI) ##1 1'b1 |=> (cfg.start_addr[19:16] == $past(i_hwdata[3:0])))
    else $error("start address high bits not stored");

  a_offset_write: assert property (@(posedge i_clk) disable iff (i_rst) // R09
    (wr_take && addr_idx == `LDMF_IDX_LO_HI) ##1 1'b1 |=> (cfg.line_offset[10:8] == $past(i_hwdata[2:0])))
    else $error("line offset high bits not stored");

  a_mode_write: assert property (@(posedge i_clk) disable iff (i_rst) // R01
    (wr_take && addr_idx == `LDMF_IDX_MODE) ##1 1'b1 |=> (bpp == $past(i_hwdata[2:0])))
    else $error("depth code not stored");

  a_misc_write: assert property (@(posedge i_clk) disable iff (i_rst) // R06
    (wr_take && addr_idx == `LDMF_IDX_MISC) ##1 1'b1 |=> (dual_buf_off == $past(i_hwdata[`LDMF_MISC_DUAL_OFF])))
    else $error("buffer-off bit not stored");

  a_dither_store: assert property (@(posedge i_clk) disable iff (i_rst) // R03
    (wr_take && addr_idx == `LDMF_IDX_MISC) ##1 1'b1 |=> (dither_off == $past(i_hwdata[`LDMF_MISC_DITHER_OFF])))
    else $error("dither-off bit not stored");

  a_pan_write: assert property (@(posedge i_clk) disable iff (i_rst) // R11
    (wr_take && addr_idx == `LDMF_IDX_PAN) ##1 1'b1 |=> (pan == $past(i_hwdata[1:0])))
    else $error("pan value not stored");

  a_pan_direct: assert property (@(posedge i_clk) disable iff (i_rst) // R12
    (bpp == `LDMF_BPP_15 || bpp == `LDMF_BPP_16) |=> (o_mode.pan_shift == 2'h0))
    else $error("direct colour panned");

  a_dither_panel: assert property (@(posedge i_clk) disable iff (i_rst) // R04
    !passive_panel |=> !o_mode.dither_en)
    else $error("dithering on an active panel");

endmodule // ldmf_regs
`default_nettype wire

// >>> sim/ldmf_panel_model.sv
// Panel-side timing source that issues frame and line start pulses
`timescale 1ns/1ps
`default_nettype none

module ldmf_panel_model (
  input wire logic i_clk, // System clock
  output logic o_frame_start, // Pulse: frame begins
  output logic o_line_start // Pulse: next display line
);
  // Both strobes idle low between requests
  initial begin
    o_frame_start = 1'b0;
    o_line_start = 1'b0;
  end

  // ---------------------------------------------------------------------------
  // Pulse tasks; frame_pulse is entered from a rising-edge time step, line_pulse from a falling-edge one
  // ---------------------------------------------------------------------------
  // Frame pulse; with both set the line strobe collides, to probe the priority
  task automatic frame_pulse(input bit both);
    @(posedge i_clk);
    o_frame_start <= 1'b1;
    o_line_start <= both;
    @(posedge i_clk);
    o_frame_start <= 1'b0;
    o_line_start <= 1'b0;
  endtask

  // Line pulse followed by a variable idle gap, so the panel can be slow or prompt
  task automatic line_pulse(input int gap);
    @(posedge i_clk);
    o_line_start <= 1'b1;
    @(posedge i_clk);
    o_line_start <= 1'b0;
    repeat (gap) @(posedge i_clk);
  endtask
endmodule // ldmf_panel_model

`default_nettype wire

// >>> sim/ldmf_regs_test.sv
// Self-checking bench for the LCD display mode and fetch register bank
`timescale 1ns/1ps
`default_nettype none
`include "ldmf_defs.svh"

module ldmf_regs_test;
  logic clk, rst, hsel, hwrite, hready, hreadyout, hresp;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic frame_start, line_start;
  logic [19:0] line_addr;
  logic [7:0] idx;
  ldmf_pkg::ldmf_mode_t mode;
  ldmf_pkg::ldmf_cfg_t cfg;
  int failures = 0;
  int compares = 0;
  int cycles = 0;
  int mdl [256];
  int la, off;

  // Single slave: its ready is the bus ready
  assign hready = hreadyout;

  ldmf_regs dut (.i_clk(clk), .i_rst(rst), .i_hsel(hsel), .i_haddr(haddr), .i_htrans(htrans),
    .i_hwrite(hwrite), .i_hsize(hsize), .i_hwdata(hwdata), .i_hready(hready), .o_hreadyout(hreadyout),
    .o_hresp(hresp), .o_hrdata(hrdata), .i_frame_start(frame_start), .i_line_start(line_start),
    .o_line_addr(line_addr), .o_mode(mode), .o_cfg(cfg));

  ldmf_panel_model pm (.i_clk(clk), .o_frame_start(frame_start), .o_line_start(line_start));

  // Clock, 10 ns period
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Hang guard, well above the roughly 1250 cycles the tests need
  always @(posedge clk) begin
    cycles = cycles + 1;
    if (cycles == 20000) begin
      failures++;
      tally_and_finish();
    end
  end

  // ---------------------------------------------------------------------------
  // Reference model
  // ---------------------------------------------------------------------------
  // Implemented bits of each byte register; unmapped and read-only places store nothing
  function automatic int mask(input int i);
    case (i)
      'h40, 'h47: return 8'h07;
      'h41, 'h48, 'h4C: return 8'h03;
      'h42, 'h43, 'h46: return 8'hFF;
      'h44: return 8'h0F;
      'h4A: return 8'h3F;
      default: return 8'h00;
    endcase
  endfunction

  // Pixel mode as packed struct (st=0) or as status register layout (st=1)
  function automatic int exp_bits(input bit st);
    int b, v, byp, dit, dual, pan;
    b = mdl[`LDMF_IDX_MODE];
    v = (b >= 2 && b <= 5);
    byp = (b == 4 || b == 5);
    dit = byp && ((mdl[`LDMF_IDX_PANEL] >> 1) & 1) && !((mdl[`LDMF_IDX_MISC] >> 1) & 1);
    dual = (mdl[`LDMF_IDX_PANEL] & 1) && !(mdl[`LDMF_IDX_MISC] & 1);
    pan = (b == 2) ? mdl[`LDMF_IDX_PAN] : (b == 3) ? (mdl[`LDMF_IDX_PAN] & 1) : 0;
    if (st) return (pan << 4) | (dual << 3) | (dit << 2) | (byp << 1) | v;
    return (v << 5) | (byp << 4) | (dit << 3) | (dual << 2) | pan;
  endfunction

  function automatic int exp_read(input int i);
    if (i == `LDMF_IDX_STATUS) return exp_bits(1);
    if (i == `LDMF_IDX_LADDR) return la;
    return mdl[i];
  endfunction

  // ---------------------------------------------------------------------------
  // Bus and compare tasks, entered from a rising-edge time step
  // ---------------------------------------------------------------------------
  task automatic bus(input logic wr, input logic [7:0] i, input logic [31:0] wd, output logic [31:0] q);
    hsel <= 1'b1;
    htrans <= `LDMF_HTRANS_NONSEQ;
    haddr <= {22'h00_0000, i, 2'b00};
    hwrite <= wr;
    @(posedge clk);
    while (hready !== 1'b1) @(posedge clk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    @(posedge clk);
    while (hready !== 1'b1) @(posedge clk);
    q = hrdata;
    chk("bus response", `LDMF_HRESP_OKAY, hresp);
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("wrong value %s: expected %h, seen %h", what, exp, got);
    end
  endtask

  task automatic wr(input logic [7:0] i, input logic [31:0] wd);
    logic [31:0] q;
    bus(1'b1, i, wd, q);
    mdl[i] = wd & mask(i);
  endtask

  task automatic rdchk(input logic [7:0] i);
    logic [31:0] q;
    bus(1'b0, i, 32'h0000_0000, q);
    chk("register read", exp_read(i), q);
  endtask

  task automatic tally_and_finish;
    $display("Comparisons %0d, mismatches %0d", compares, failures);
    if (failures == 0 && compares > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // ---------------------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------------------
  initial begin
    rst = 1'b1;
    hsel = 1'b0;
    htrans = 2'h0;
    haddr = 32'h0000_0000;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0000_0000;
    foreach (mdl[i]) mdl[i] = 0;
    la = 0;
    void'($urandom(42));
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    // Reset contents of the whole window, unmapped places included
    for (int i = 'h40; i < 'h50; i++) rdchk(i[7:0]);
    $display("reset test done");
    // Random writes, each followed by a read of the same or another place
    for (int n = 0; n < 60; n++) begin
      idx = 8'h40 + 8'($urandom % 16);
      wr(idx, $urandom);
      if (n % 2) idx = 8'h40 + 8'($urandom % 16);
      rdchk(idx);
    end
    $display("register test done");
    // Every depth code against dither and panel type settings, with a random buffer-off bit
    for (int i = 0; i < 64; i++) begin
      wr(`LDMF_IDX_MODE, i & 7);
      wr(`LDMF_IDX_MISC, (((i >> 3) & 1) << 1) | ($urandom % 2));
      wr(`LDMF_IDX_PANEL, (i >> 4) & 3);
      wr(`LDMF_IDX_PAN, $urandom);
      repeat (2) @(posedge clk);
      @(negedge clk);
      chk("pixel mode", exp_bits(0), mode);
      @(posedge clk);
      rdchk(`LDMF_IDX_STATUS);
    end
    $display("mode test done");
    // Line address walk; pass 1 collides frame and line, pass 3 wraps 20 bits
    // A legal depth is set first, so panning has a defined meaning
    wr(`LDMF_IDX_MODE, `LDMF_BPP_4);
    for (int k = 0; k < 4; k++) begin
      wr(`LDMF_IDX_PAN, k);
      wr(`LDMF_IDX_SA_LO, $urandom);
      wr(`LDMF_IDX_SA_MID, (k == 3) ? 8'hFF : $urandom);
      wr(`LDMF_IDX_SA_HI, (k == 3) ? 8'hFF : $urandom);
      wr(`LDMF_IDX_LO_LO, (k == 3) ? 8'hFF : $urandom);
      wr(`LDMF_IDX_LO_HI, (k == 3) ? 8'hFF : $urandom);
      la = (mdl[`LDMF_IDX_SA_HI] << 16) | (mdl[`LDMF_IDX_SA_MID] << 8) | mdl[`LDMF_IDX_SA_LO];
      off = (mdl[`LDMF_IDX_LO_HI] << 8) | mdl[`LDMF_IDX_LO_LO];
      pm.frame_pulse(k == 1);
      @(negedge clk);
      chk("start address", la, cfg.start_addr);
      chk("first line address", la, line_addr);
      chk("line offset", off, cfg.line_offset);
      chk("pan shift", k, mode.pan_shift);
      for (int j = 0; j < 5; j++) begin
        pm.line_pulse($urandom % 3);
        @(negedge clk);
        la = (la + off) & 20'hF_FFFF;
        chk("next line address", la, line_addr);
      end
      @(posedge clk);
      rdchk(`LDMF_IDX_LADDR);
    end
    $display("line address test done");
    // Dual buffer switched off before the display would be blanked
    wr(`LDMF_IDX_MISC, 32'h0000_0001);
    rdchk(`LDMF_IDX_MISC);
    tally_and_finish();
  end
endmodule // ldmf_regs_test

`default_nettype wire
